// [logic/cwd_regs.svh]
// register offsets, field positions, reset values and timing counts of the setup decoder
`ifndef CWD_REGS_SVH
`define CWD_REGS_SVH

// ********************************
// register offsets
// ********************************
`define CWD_OFF_SETUP   4'h0
`define CWD_OFF_CTRL    4'h4
`define CWD_OFF_STATUS  4'h8

// ********************************
// setup word fields
// ********************************
`define CWD_WORD_W      12
`define CWD_IMPL_W      10
`define CWD_UNIMPL_BITS 2'h3
`define CWD_ERASED      10'h3ff
`define CWD_B_START_DELAY_TIMER_ENABLE     9
`define CWD_B_BROWNOUT_RESET_ENABLE     8
`define CWD_B_SWPROT    7
`define CWD_B_IOSC      6
`define CWD_B_EXTRST    5
`define CWD_B_PGMPROT   4
`define CWD_B_WDTEN     3
`define CWD_B_OSC_HI    2

// ********************************
// control and status bits
// ********************************
`define CWD_C_ERASE     0
`define CWD_C_SLEEP     1
`define CWD_C_WDTCLR    2
`define CWD_S_LATCH     0
`define CWD_S_SLEEP     1
`define CWD_S_WDTTO     2
`define CWD_S_DLYRUN    3

// ********************************
// timing
// ********************************
`define CWD_CLK_PERIOD_NS  10
`define CWD_LONG_DELAY_MS  18
`define CWD_SHORT_DELAY_US 10
`define CWD_LONG_CYC  ((`CWD_LONG_DELAY_MS * 1000000) / `CWD_CLK_PERIOD_NS)
`define CWD_SHORT_CYC ((`CWD_SHORT_DELAY_US * 1000) / `CWD_CLK_PERIOD_NS)
`define CWD_DLY_W     21
`define CWD_WDT_W     8
`define CWD_WDT_TICKS 8'hff

`endif

// [logic/cwd_pkg.sv]
// types shared by the setup word decoder
package cwd_pkg;

  // ********************************
  // oscillator select codes
  // ********************************
  typedef enum logic [2:0] {
    CWD_OSC_LP_XTAL  = 3'b000,
    CWD_OSC_STD_XTAL = 3'b001,
    CWD_OSC_HS_XTAL  = 3'b010,
    CWD_OSC_EXT_CLK  = 3'b011,
    CWD_OSC_INT_RC   = 3'b100,
    CWD_OSC_INT_RC_CO = 3'b101,
    CWD_OSC_EXT_RC   = 3'b110,
    CWD_OSC_EXT_RC_CO = 3'b111
  } cwd_osc_e;

  // ********************************
  // decoded options
  // ********************************
  typedef struct packed {
    cwd_osc_e osc_select_field;
    logic     start_delay_timer_enable;
    logic     long_start_delay;
    logic     brownout_reset_enable;
    logic     self_write_mem_protect;
    logic     internal_osc_speed_select;
    logic     ext_reset_pin_enable;
    logic     program_mem_protect;
    logic     watchdog_enable;
    logic     clock_output_function;
    logic     shared_osc_io_pin_gpio;
    logic     crystal_mode;
  } cwd_opts_s;

endpackage

// [logic/cwd_tick_counter.sv]
// counter that pulses once each time it has counted limit enabled cycles
`timescale 1ns/1ps
module cwd_tick_counter #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] cnt_q;
  logic         last;

  assign last = (cnt_q == limit - W'(1));

  // clear wins over counting so a fresh reset cause restarts the full span
  always_ff @(posedge clk) begin
    if (!rstn || clr) begin
      cnt_q <= '0;
      done  <= 1'b0;
    end else if (en && last) begin
      cnt_q <= '0;
      done  <= 1'b1;
    end else begin
      cnt_q <= en ? cnt_q + W'(1) : cnt_q;
      done  <= 1'b0;
    end
  end

endmodule

// [logic/cwd_top.sv]
// setup word holder, option decoder, start delay, watchdog and sleep control
//
// Summary of operation
// - 12-bit word, top two bits read one
// - erased word reads all ones
// - bit 9 enables 18 ms start delay
// - crystal modes always use 18 ms delay
// - other modes 10 us, 18 ms if enabled
// - bit 8 enables brown-out reset
// - bit 7 low protects self-write memory
// - bit 6 picks 8 or 4 MHz
// - bit 5 makes pin the external reset
// - only bit 3 enables the watchdog
// - watchdog ticks from its own oscillator
// - codes 000-010 pick crystal modes
// - codes 011,100,110 keep second pin general
// - codes 101,111 drive clock output
// - crystal modes accept external clock too
// - sleep ends on pin change or watchdog
// - latch set, timer waits pin high if bit 5 set
`timescale 1ns/1ps
`include "cwd_regs.svh"
module cwd_top #(
  parameter int unsigned DLY_LONG_CYC = `CWD_LONG_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [31:0]      bus_rdata,
  input  wire logic        external_reset_pin_n,
  input  wire logic        brownout_detect,
  input  wire logic        wdt_rc_tick,
  input  wire logic        wake_pin_change,
  output cwd_pkg::cwd_opts_s opts,
  output logic             device_reset,
  output logic             sleep_state,
  output logic             wake_pulse,
  output logic             wdt_timeout,
  output logic             reset_pin_gpio_in
);

  // ********************************
  // storage
  // ********************************
  logic [`CWD_IMPL_W-1:0] word_q;
  logic [`CWD_IMPL_W-1:0] act_q;
  logic                   latch_q;
  logic                   sleep_q;
  logic                   wdt_sticky_q;
  logic                   dly_run_q;
  logic [31:0]            rdata_q;
  cwd_pkg::cwd_opts_s     opts_q;
  cwd_pkg::cwd_opts_s     opts_d;
  logic                   wake_q;
  logic                   wdt_to_q;
  logic                   gpio_q;

  // ********************************
  // bus decode
  // ********************************
  wire sel_setup  = (bus_addr == `CWD_OFF_SETUP);
  wire sel_ctrl   = (bus_addr == `CWD_OFF_CTRL);
  wire sel_status = (bus_addr == `CWD_OFF_STATUS);
  wire wr_setup   = bus_wr && sel_setup;
  wire wr_ctrl    = bus_wr && sel_ctrl;
  wire wr_status  = bus_wr && sel_status;
  wire do_erase   = wr_ctrl && bus_wdata[`CWD_C_ERASE];
  wire do_sleep   = wr_ctrl && bus_wdata[`CWD_C_SLEEP];
  wire do_wdtclr  = wr_ctrl && bus_wdata[`CWD_C_WDTCLR];
  wire clr_wdtsts = wr_status && bus_wdata[`CWD_S_WDTTO];

  // unimplemented top bits always read back as ones
  wire [`CWD_WORD_W-1:0] word_rd = {`CWD_UNIMPL_BITS, word_q};

  wire [31:0] status_rd = {28'h0, dly_run_q, wdt_sticky_q, sleep_q, latch_q};

  wire [31:0] rd_mux = sel_setup  ? {20'h0, word_rd} :
                       sel_status ? status_rd : 32'h0;

  // ********************************
  // option decode from the latched word
  // ********************************
  wire [2:0] osc_code = act_q[`CWD_B_OSC_HI:0];
  wire is_xtal  = (osc_code == cwd_pkg::CWD_OSC_LP_XTAL)
               || (osc_code == cwd_pkg::CWD_OSC_STD_XTAL)
               || (osc_code == cwd_pkg::CWD_OSC_HS_XTAL);
  wire clk_out  = (osc_code == cwd_pkg::CWD_OSC_INT_RC_CO)
               || (osc_code == cwd_pkg::CWD_OSC_EXT_RC_CO);
  wire drt_en   = act_q[`CWD_B_START_DELAY_TIMER_ENABLE];
  // crystals ignore the enable bit; the others lengthen only on request
  wire long_dly = is_xtal || drt_en;
  wire bor_en   = act_q[`CWD_B_BROWNOUT_RESET_ENABLE];
  wire ext_en   = act_q[`CWD_B_EXTRST];
  wire wdt_en   = act_q[`CWD_B_WDTEN];

  // decoded options as one bundle, registered before leaving the block
  always_comb begin
    opts_d = '0;
    opts_d.osc_select_field          = cwd_pkg::cwd_osc_e'(osc_code);
    opts_d.start_delay_timer_enable  = drt_en;
    opts_d.long_start_delay          = long_dly;
    opts_d.brownout_reset_enable     = bor_en;
    opts_d.self_write_mem_protect    = ~act_q[`CWD_B_SWPROT];
    opts_d.internal_osc_speed_select = act_q[`CWD_B_IOSC];
    opts_d.ext_reset_pin_enable      = ext_en;
    opts_d.program_mem_protect       = ~act_q[`CWD_B_PGMPROT];
    opts_d.watchdog_enable           = wdt_en;
    opts_d.clock_output_function     = clk_out;
    opts_d.shared_osc_io_pin_gpio    = !is_xtal && !clk_out;
    // first pin also takes a driven clock; second pin drive stays weak
    opts_d.crystal_mode              = is_xtal;
  end

  // ********************************
  // reset causes and start delay
  // ********************************
  logic dly_done;
  logic wdt_done;

  // with the pin given over to general input the external reset is inert
  wire pin_rst   = ext_en && !external_reset_pin_n;
  wire pin_high  = !ext_en || external_reset_pin_n;
  wire bor_rst   = bor_en && brownout_detect;
  wire wdt_rst   = wdt_done && !sleep_q;
  wire rst_cause = pin_rst || bor_rst || wdt_rst;

  wire [`CWD_DLY_W-1:0] dly_limit = long_dly ? `CWD_DLY_W'(DLY_LONG_CYC)
                                             : `CWD_DLY_W'(`CWD_SHORT_CYC);

  // timer is cleared by any cause and counts only with the pin high or the pin not used as external reset
  wire dly_clr = rst_cause || !latch_q;
  wire dly_en  = latch_q && pin_high;

  cwd_tick_counter #(
    .W (`CWD_DLY_W)
  ) u_dly (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (dly_clr),
    .en    (dly_en),
    .limit (dly_limit),
    .done  (dly_done)
  );

  // ********************************
  // watchdog on its own oscillator ticks
  // ********************************
  // only the setup bit or the reset latch stops it; software can merely restart it
  wire wdt_clr = !wdt_en || do_wdtclr || latch_q;
  wire wdt_cnt = wdt_en && wdt_rc_tick;

  cwd_tick_counter #(
    .W (`CWD_WDT_W)
  ) u_wdt (
    .clk   (clk),
    .rstn  (rstn),
    .clr   (wdt_clr),
    .en    (wdt_cnt),
    .limit (`CWD_WDT_TICKS),
    .done  (wdt_done)
  );

  wire wake_now = sleep_q && (wake_pin_change || wdt_done);

  // ********************************
  // nonvolatile word and latched copy
  // ********************************
  // word starts erased; erase beats a program in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      word_q <= `CWD_ERASED;
    end else if (do_erase) begin
      word_q <= `CWD_ERASED;
    end else if (wr_setup) begin
      word_q <= bus_wdata[`CWD_IMPL_W-1:0];
    end
  end

  // copy follows the stored word only while the device is held in reset,
  // so a program write never changes a running configuration
  always_ff @(posedge clk) begin
    if (!rstn) begin
      act_q <= `CWD_ERASED;
    end else if (latch_q) begin
      act_q <= word_q;
    end
  end

  // ********************************
  // reset latch and sleep
  // ********************************
  // a fresh cause outranks a timer expiry in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      latch_q <= 1'b1;
    end else if (rst_cause) begin
      latch_q <= 1'b1;
    end else if (dly_done) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || latch_q || wake_now) begin
      sleep_q <= 1'b0;
    end else if (do_sleep) begin
      sleep_q <= 1'b1;
    end
  end

  // timeout flag: a new timeout wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdt_sticky_q <= 1'b0;
    end else if (wdt_done) begin
      wdt_sticky_q <= 1'b1;
    end else if (clr_wdtsts) begin
      wdt_sticky_q <= 1'b0;
    end
  end

  // ********************************
  // output and read data flops
  // ********************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      opts_q    <= '0;
      dly_run_q <= 1'b0;
      wake_q    <= 1'b0;
      wdt_to_q  <= 1'b0;
      gpio_q    <= 1'b0;
      rdata_q   <= 32'h0;
    end else begin
      opts_q    <= opts_d;
      dly_run_q <= dly_en && !dly_clr;
      wake_q    <= wake_now;
      wdt_to_q  <= wdt_done;
      gpio_q    <= ext_en ? 1'b0 : external_reset_pin_n;
      rdata_q   <= bus_rd ? rd_mux : 32'h0;
    end
  end

  assign bus_rdata         = rdata_q;
  assign opts              = opts_q;
  assign device_reset      = latch_q;
  assign sleep_state       = sleep_q;
  assign wake_pulse        = wake_q;
  assign wdt_timeout       = wdt_to_q;
  assign reset_pin_gpio_in = gpio_q;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_erase;
    bus_wr && sel_ctrl && bus_wdata[`CWD_C_ERASE];
  endsequence

  sequence s_read_setup;
    bus_rd && sel_setup;
  endsequence

  AST_UNIMPL_ONES: assert property (
    s_read_setup |=> bus_rdata[11:10] == `CWD_UNIMPL_BITS)
    else $error("setup word top bits did not read one");

  AST_ERASE_ALL_ONES: assert property (
    s_erase ##1 s_read_setup |=> bus_rdata[11:0] == 12'hfff)
    else $error("erased word did not read all ones");

  AST_RC_DELAY_SEL: assert property (
    !is_xtal |-> dly_limit == (drt_en ? `CWD_DLY_W'(DLY_LONG_CYC)
                                     : `CWD_DLY_W'(`CWD_SHORT_CYC)))
    else $error("start delay length wrong in non crystal mode");

  AST_XTAL_LONG: assert property (
    is_xtal |=> opts.long_start_delay)
    else $error("crystal mode without long start delay");

  AST_BOR_FOLLOWS: assert property (
    bor_en && brownout_detect |=> device_reset)
    else $error("brown-out did not hold the device in reset");

  AST_PIN_IGNORED: assert property (
    !ext_en && !device_reset && !wdt_done && !bor_rst
    |=> !device_reset)
    else $error("reset taken while the pin is general input");

  AST_WDT_OFF: assert property (
    !wdt_en |=> !wdt_timeout)
    else $error("watchdog fired while disabled");

  AST_WAKE_PIN: assert property (
    sleep_state && wake_pin_change && !device_reset
    |=> wake_pulse ##1 !sleep_state)
    else $error("pin change did not wake from sleep");

  AST_WAIT_PIN: assert property (
    device_reset && ext_en && !external_reset_pin_n
    |=> device_reset && !dly_done)
    else $error("start delay ran while the reset pin was low");

  AST_CLOCK_OUTPUT_FUNCTION: assert property (
    clk_out |=> opts.clock_output_function && !opts.shared_osc_io_pin_gpio)
    else $error("clock output mode decoded wrongly");

  // a sleeping device treats an expiry as a wake-up, never as a reset
  sequence s_sleep_expiry;
    sleep_state && wdt_done && !device_reset && !pin_rst && !bor_rst;
  endsequence

  AST_WDT_WAKE: assert property (
    s_sleep_expiry |=> wake_pulse && wdt_timeout && !sleep_state && !device_reset)
    else $error("watchdog expiry in sleep did not wake cleanly");

  AST_WDT_RESET: assert property (
    wdt_done && !sleep_state |=> device_reset && wdt_timeout)
    else $error("watchdog expiry while awake did not reset");

  AST_EXT_RST: assert property (
    ext_en && !external_reset_pin_n |=> device_reset)
    else $error("enabled reset pin low did not hold reset");

  AST_DLY_RELEASE: assert property (
    dly_done && !rst_cause |=> !device_reset)
    else $error("reset latch not released at delay end");

  AST_IOSC_SEL: assert property (
    act_q[`CWD_B_IOSC] |=> opts.internal_osc_speed_select)
    else $error("fast internal oscillator not selected");

  AST_IOSC_LOW: assert property (
    !act_q[`CWD_B_IOSC] |=> !opts.internal_osc_speed_select)
    else $error("slow internal oscillator not selected");

  AST_SWPROT: assert property (
    !act_q[`CWD_B_SWPROT] |=> opts.self_write_mem_protect)
    else $error("self-write memory left unprotected");

  AST_PGMPROT: assert property (
    !act_q[`CWD_B_PGMPROT] |=> opts.program_mem_protect)
    else $error("program memory left unprotected");

endmodule

// [bench/cwd_far_model.sv]
// far-side model: reset pin, brown-out comparator, watchdog oscillator, wake pin
`timescale 1ns/1ps
module cwd_far_model (
  input  wire logic clk,
  input  wire logic pin_hold,
  input  wire logic bor_req,
  input  wire logic osc_run,
  input  wire logic wake_req,
  output logic      external_reset_pin_n,
  output logic      brownout_detect,
  output logic      wdt_rc_tick,
  output logic      wake_pin_change
);
  logic [1:0] div_q = 2'h0;

  // ****************************************
  // pins and comparator
  // ****************************************
  // the reset pin has a pull-up, so a released pin reads high
  assign external_reset_pin_n = ~pin_hold;
  assign brownout_detect      = bor_req;
  assign wake_pin_change      = wake_req;

  // ****************************************
  // watchdog oscillator
  // ****************************************
  // divided down on its own counter so its rate has nothing to do with bus traffic
  always @(posedge clk) begin
    div_q       <= div_q + 2'h1;
    wdt_rc_tick <= osc_run && (div_q == 2'h3);
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the setup word decoder
`timescale 1ns/1ps
`include "cwd_regs.svh"
module tb_top;
  localparam int unsigned DLY = 50;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic [3:0]         bus_addr = 4'h0;
  logic [31:0]        bus_wdata = 32'h0;
  logic               bus_wr = 1'b0;
  logic               bus_rd = 1'b0;
  logic [31:0]        bus_rdata;
  logic               pin_hold = 1'b0;
  logic               bor_req = 1'b0;
  logic               osc_run = 1'b0;
  logic               wake_req = 1'b0;
  wire                pin_n;
  wire                bor;
  wire                tick;
  wire                wake;
  cwd_pkg::cwd_opts_s opts;
  logic               device_reset;
  logic               sleep_state;
  logic               wake_pulse;
  logic               wdt_timeout;
  logic               gpio_in;
  logic [31:0]        rd_q;
  logic [11:0]        w;
  int                 fail_count = 0;
  int                 compares = 0;
  int                 cyc = 0;
  int                 n;

  always #5 clk = ~clk;

  cwd_top #(.DLY_LONG_CYC(DLY)) i_cwd_top (.clk(clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .external_reset_pin_n(pin_n), .brownout_detect(bor), .wdt_rc_tick(tick),
    .wake_pin_change(wake), .opts(opts), .device_reset(device_reset),
    .sleep_state(sleep_state), .wake_pulse(wake_pulse), .wdt_timeout(wdt_timeout),
    .reset_pin_gpio_in(gpio_in));

  cwd_far_model i_cwd_far_model (.clk(clk), .pin_hold(pin_hold), .bor_req(bor_req),
    .osc_run(osc_run), .wake_req(wake_req), .external_reset_pin_n(pin_n),
    .brownout_detect(bor), .wdt_rc_tick(tick), .wake_pin_change(wake));

  // ****************************************
  // compare, bus and reset tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 rd_q = bus_rdata;
  endtask

  // hold a reset cause, release it, and count cycles until the latch drops
  task automatic kick(input logic use_bor, output int cnt);
    @(posedge clk);
    if (use_bor) bor_req <= 1'b1;
    else pin_hold <= 1'b1;
    repeat (20) @(posedge clk);
    chk1(device_reset, 1'b1);
    bor_req <= 1'b0;
    pin_hold <= 1'b0;
    cnt = 0;
    while (device_reset !== 1'b0 && cnt < 3000) begin
      @(posedge clk);
      #1 cnt++;
    end
  endtask

  // decode expected from the word itself, field order as the option struct
  function automatic cwd_pkg::cwd_opts_s exp_opts(input logic [11:0] x);
    exp_opts = {x[2:0], x[9], (x[2:0] < 3'h3) | x[9], x[8], ~x[7], x[6], x[5], ~x[4],
                x[3], x[2] & x[0], (x[2:0] >= 3'h3) & ~(x[2] & x[0]), x[2:0] < 3'h3};
  endfunction

  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // hang guard
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      conclude;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(`CWD_OFF_SETUP);
    chk(rd_q, 32'h00000fff);
    chk({18'h0, opts}, {18'h0, exp_opts(12'hfff)});
    kick(1'b0, n);
    chk(32'(n >= DLY && n <= DLY + 4), 32'h1);
    rd(4'hc);
    chk(rd_q, 32'h0);
    rd(`CWD_OFF_CTRL);
    chk(rd_q, 32'h0);
    // every oscillator code with the delay enable cleared
    for (int c = 0; c < 8; c++) begin
      w = 12'hdf8 | 12'(c);
      wr(`CWD_OFF_SETUP, {20'h0, w});
      kick(1'b0, n);
      chk({18'h0, opts}, {18'h0, exp_opts(w)});
      chk(32'(n >= (c < 3 ? DLY : 1000) && n <= (c < 3 ? DLY : 1000) + 4), 32'h1);
    end
    // external reset option cleared, reset pin becomes a plain input
    wr(`CWD_OFF_SETUP, 32'h00000105);
    kick(1'b0, n);
    chk({18'h0, opts}, {18'h0, exp_opts(12'h105)});
    rd(`CWD_OFF_SETUP);
    chk(rd_q, 32'h00000d05);
    @(posedge clk);
    pin_hold <= 1'b1;
    repeat (5) @(posedge clk);
    pin_hold <= 1'b0;
    #1 chk1(device_reset, 1'b0);
    chk1(gpio_in, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk1(gpio_in, 1'b1);
    // erase, then reload through the brown-out path
    wr(`CWD_OFF_CTRL, 32'h1);
    rd(`CWD_OFF_SETUP);
    chk(rd_q, 32'h00000fff);
    kick(1'b1, n);
    chk({18'h0, opts}, {18'h0, exp_opts(12'hfff)});
    // watchdog expiry while awake
    wr(`CWD_OFF_CTRL, 32'h4);
    osc_run <= 1'b1;
    n = 0;
    for (int k = 0; k < 3000 && wdt_timeout !== 1'b1; k++) begin
      @(posedge clk);
      #1 if (tick === 1'b1) n++;
    end
    osc_run <= 1'b0;
    chk(32'(n), 32'd255);
    @(posedge clk);
    #1 chk1(device_reset, 1'b1);
    for (int k = 0; k < 3000 && device_reset !== 1'b0; k++) @(posedge clk);
    chk1(device_reset, 1'b0);
    rd(`CWD_OFF_STATUS);
    chk(rd_q, 32'h00000004);
    wr(`CWD_OFF_STATUS, 32'h4);
    rd(`CWD_OFF_STATUS);
    chk(rd_q, 32'h0);
    // sleep and wake on pin change
    wr(`CWD_OFF_CTRL, 32'h2);
    #1 chk1(sleep_state, 1'b1);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    #1 chk1(wake_pulse, 1'b1);
    chk1(sleep_state, 1'b0);
    // watchdog expiry while asleep wakes without a reset
    wr(`CWD_OFF_CTRL, 32'h6);
    osc_run <= 1'b1;
    for (int k = 0; k < 3000 && wake_pulse !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    osc_run <= 1'b0;
    chk1(wake_pulse, 1'b1);
    chk1(wdt_timeout, 1'b1);
    chk1(sleep_state, 1'b0);
    chk1(device_reset, 1'b0);
    rd(`CWD_OFF_STATUS);
    chk(rd_q, 32'h00000004);
    // a mid-run reset drops the programmed word and holds the device in reset
    wr(`CWD_OFF_SETUP, 32'h000002aa);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk1(device_reset, 1'b1);
    chk({18'h0, opts}, 32'h0);
    rd(`CWD_OFF_SETUP);
    chk(rd_q, 32'h00000fff);
    conclude;
  end
endmodule
